// file: hdl/gpp_port.sv
/*
 gpp_port: nine software-configured general-purpose pins with apb registers;
 low pins may carry pwm channels instead. each pin is three signals.
 assumes: pins synchronous to clk; board adds pull-ups for open-drain pins;
 role strap is stable around reset release.
*/
// Design decisions made here: the register addresses and the APB slave port.
// Behaviour
// [RULE1] nine general-purpose pins, numbered 0 to 8, each controlled on its own
// [RULE2] each pin set by software to input, output, bidirectional or open-drain
// [RULE3] after reset every pin is an input and nothing is driven
// [RULE4] pins 0 to 3 may carry the pwm channel of the same index
// [RULE5] a per-pin function select picks plain pin or alternative function
// [RULE6] as secondary controller the pins are reserved and never driven
// [RULE7] role strap high means primary, low means secondary
// [RULE8] open-drain drives low for value zero, releases for value one
`timescale 1ns/10ps
module gpp_port #(
   parameter int NUM_PINS = 9,
   parameter int NUM_PWM = 4,
   parameter int PWM_W = 16
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic ce,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic role_strap,
   input wire logic [NUM_PINS-1:0] pin_in,
   output logic [NUM_PINS-1:0] pin_out,
   output logic [NUM_PINS-1:0] pin_oe_n
);
   // =====================================================================
   // elaboration checks
   // mode needs two bits per pin inside one 32-bit word
   if (NUM_PINS > 16) begin : g_chk_pins
      $error("gpp_port: NUM_PINS must be 16 or less");
   end
   // pwm channels sit on the low pins and own four address slots
   if (NUM_PWM < 1 || NUM_PWM >= NUM_PINS || NUM_PWM > 4) begin : g_chk_pwm
      $error("gpp_port: NUM_PWM must be 1 to 4 and below NUM_PINS");
   end
   // period and duty each own one half of the channel word
   if (PWM_W < 1 || PWM_W > 16) begin : g_chk_width
      $error("gpp_port: PWM_W must be 1 to 16");
   end

   typedef struct packed {
      logic [2*NUM_PINS-1:0] mode;
      logic [NUM_PINS-1:0] outv;
      logic [NUM_PINS-1:0] drv;
      logic [NUM_PWM-1:0] func;
      logic [NUM_PWM*32-1:0] pwmcfg;
      logic [NUM_PINS-1:0] inv;
      logic role_valid;
      logic primary;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
      logic [NUM_PINS-1:0] pout;
      logic [NUM_PINS-1:0] poe_n;
   } gpp_state_t;

   // =====================================================================
   // reset release
   // reset enters asynchronously and leaves on the second edge; the sync
   // ignores ce so a frozen block still comes out of reset cleanly
   logic rst_meta_q, rst_n_q;
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rst_meta_q <= 1'b0;
         rst_n_q <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_n_q <= rst_meta_q;
      end
   end

   // =====================================================================
   // pwm channels
   // channel word k: period in the low half, duty in the high half
   logic [NUM_PWM-1:0] pwm_w;
   gpp_state_t s_q, s_d;

   for (genvar k = 0; k < NUM_PWM; k++) begin : g_pwm
      gpp_pwm_chan #(.W(PWM_W)) u_chan (
         .clk(clk),
         .rst_n(rst_n_q),
         .ce(ce),
         .period(s_q.pwmcfg[k*32+gpp_pkg::PWM_PERIOD_LSB +: PWM_W]),
         .duty(s_q.pwmcfg[k*32+gpp_pkg::PWM_DUTY_LSB +: PWM_W]),
         .pwm_q(pwm_w[k])
      );
   end

   // =====================================================================
   // next state
   logic [NUM_PINS-1:0] pwm_pin, func_pin;
   assign pwm_pin = {{(NUM_PINS-NUM_PWM){1'b0}}, pwm_w};
   assign func_pin = {{(NUM_PINS-NUM_PWM){1'b0}}, s_q.func};

   // =====================================================================
   // pin drivers, one slice per pin
   // open-drain never drives high: its value is forced low and the enable
   // alone carries the level, the board pull-up supplies the one
   wire logic [NUM_PINS-1:0] pin_val_w;
   wire logic [NUM_PINS-1:0] pin_drv_w;

   for (genvar i = 0; i < NUM_PINS; i++) begin : g_pin
      logic [1:0] md;
      logic val;
      logic drive;
      assign md = s_q.mode[i*gpp_pkg::MODE_FIELD_W +: gpp_pkg::MODE_FIELD_W];
      assign val = func_pin[i] ? pwm_pin[i] : s_q.outv[i]; // [RULE4]
      always_comb begin
         case (md)
            gpp_pkg::MODE_INPUT: drive = 1'b0; // [RULE3]
            gpp_pkg::MODE_OUTPUT: drive = 1'b1; // [RULE2]
            gpp_pkg::MODE_BIDIR: drive = s_q.drv[i];
            gpp_pkg::MODE_OPEN_DRAIN: drive = !val; // [RULE8]
            default: drive = 1'b0;
         endcase
         // until the strap is known the pins stay released
         if (!(s_q.role_valid && s_q.primary)) begin
            drive = 1'b0; // [RULE6]
         end
      end
      assign pin_val_w[i] = (md == gpp_pkg::MODE_OPEN_DRAIN) ? 1'b0 : val; // [RULE8]
      assign pin_drv_w[i] = drive;
   end

   // =====================================================================
   // bus and register next state
   always_comb begin
      logic setup, wr, hit;
      logic [31:0] rd;
      setup = psel && !penable;
      wr = psel && penable && s_q.pready && pwrite;
      hit = 1'b1;
      rd = 32'h0000_0000;
      s_d = s_q;
      // pins are taken as synchronous; a pin from another clock needs a synchroniser outside
      s_d.inv = pin_in;
      // strap taken once, on the first enabled edge after reset release
      if (!s_q.role_valid) begin
         s_d.role_valid = 1'b1;
         s_d.primary = role_strap; // [RULE7]
      end
      // bus: read data and error prepared in setup, pready high in access;
      // registered answers cost no wait state but keep every output on a flop,
      // and a low ce at the setup edge keeps pready low for good, so the access phase never completes
      s_d.pready = setup;
      case (paddr)
         gpp_pkg::OFF_MODE: rd = 32'(s_q.mode);
         gpp_pkg::OFF_OUT: rd = 32'(s_q.outv);
         gpp_pkg::OFF_IN: rd = 32'(s_q.inv);
         gpp_pkg::OFF_FUNC: rd = 32'(s_q.func);
         gpp_pkg::OFF_DRV: rd = 32'(s_q.drv);
         gpp_pkg::OFF_STATUS: begin
            rd[gpp_pkg::STATUS_PRIMARY_BIT] = s_q.primary;
            rd[gpp_pkg::STATUS_ROLE_VALID_BIT] = s_q.role_valid;
         end
         default: hit = 1'b0;
      endcase
      for (int k = 0; k < NUM_PWM; k++) begin
         if (paddr == 8'(gpp_pkg::OFF_PWM0 + 8'(k) * gpp_pkg::PWM_STRIDE)) begin
            hit = 1'b1;
            rd = s_q.pwmcfg[k*32 +: 32];
            if (wr) begin
               s_d.pwmcfg[k*32 +: 32] = pwdata;
            end
         end
      end
      if (setup) begin
         s_d.prdata = pwrite ? 32'h0000_0000 : rd;
         s_d.pslverr = !hit;
      end else if (!psel) begin
         s_d.pslverr = 1'b0;
         s_d.prdata = 32'h0000_0000;
      end
      // =================================================================
      // register writes
      if (wr) begin
         case (paddr)
            gpp_pkg::OFF_MODE: s_d.mode = pwdata[2*NUM_PINS-1:0]; // [RULE2]
            gpp_pkg::OFF_OUT: s_d.outv = pwdata[NUM_PINS-1:0]; // [RULE1]
            gpp_pkg::OFF_FUNC: s_d.func = pwdata[NUM_PWM-1:0]; // [RULE5]
            gpp_pkg::OFF_DRV: s_d.drv = pwdata[NUM_PINS-1:0];
            default: ;
         endcase
      end
      // pin drivers come from the per-pin slices above
      s_d.pout = pin_val_w;
      s_d.poe_n = ~pin_drv_w;
   end

   // =====================================================================
   // state register
   always_ff @(posedge clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         s_q <= '0;
         s_q.mode <= (2*NUM_PINS)'(gpp_pkg::RST_MODE); // [RULE3]
         s_q.outv <= NUM_PINS'(gpp_pkg::RST_OUT);
         s_q.drv <= NUM_PINS'(gpp_pkg::RST_DRV);
         s_q.func <= NUM_PWM'(gpp_pkg::RST_FUNC);
         s_q.pwmcfg <= {NUM_PWM{gpp_pkg::RST_PWM}};
         s_q.poe_n <= '1; // [RULE3]
      end else if (ce) begin
         s_q <= s_d;
      end
   end

   assign prdata = s_q.prdata;
   assign pready = s_q.pready;
   assign pslverr = s_q.pslverr;
   assign pin_out = s_q.pout;
   assign pin_oe_n = s_q.poe_n;
endmodule // gpp_port

// file: hdl/gpp_pwm_chan.sv
/*
 gpp_pwm_chan: one pwm channel; counter runs 0..period-1, output high while
 the count is below duty. period zero holds the output low.
 assumes: clk and synchronised active-low reset from the parent; ce freezes it.
*/
`timescale 1ns/10ps
module gpp_pwm_chan #(
   parameter int W = 16
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic [W-1:0] period,
   input wire logic [W-1:0] duty,
   output logic pwm_q
);
   typedef struct packed {
      logic [W-1:0] cnt;
      logic out;
   } gpp_pwm_state_t;

   gpp_pwm_state_t s_q, s_d;

   always_comb begin
      s_d = s_q;
      if (period == '0) begin
         s_d.cnt = '0;
         s_d.out = 1'b0;
      end else begin
         if (s_q.cnt >= period - W'(1)) begin
            s_d.cnt = '0;
         end else begin
            s_d.cnt = s_q.cnt + W'(1);
         end
         s_d.out = (s_q.cnt < duty);
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_q <= '0;
      end else if (ce) begin
         s_q <= s_d;
      end
   end

   assign pwm_q = s_q.out;
endmodule // gpp_pwm_chan

// file: include/gpp_pkg.sv
/*
 gpp_pkg: register map, field layout, reset values and pin mode codes of the
 general-purpose pin port with its pwm alternative function.
 assumes: a 32-bit apb slave with one aligned word per register.
*/
package gpp_pkg;
   // =====================================================================
   // register byte offsets
   localparam logic [7:0] OFF_MODE = 8'h00;
   localparam logic [7:0] OFF_OUT = 8'h04;
   localparam logic [7:0] OFF_IN = 8'h08;
   localparam logic [7:0] OFF_FUNC = 8'h0C;
   localparam logic [7:0] OFF_DRV = 8'h10;
   localparam logic [7:0] OFF_STATUS = 8'h14;
   localparam logic [7:0] OFF_PWM0 = 8'h20;
   localparam logic [7:0] PWM_STRIDE = 8'h04;
   // =====================================================================
   // field positions
   localparam int MODE_FIELD_W = 2;
   localparam int STATUS_PRIMARY_BIT = 0;
   localparam int STATUS_ROLE_VALID_BIT = 1;
   localparam int PWM_PERIOD_LSB = 0;
   localparam int PWM_DUTY_LSB = 16;
   // =====================================================================
   // pin mode codes
   localparam logic [1:0] MODE_INPUT = 2'h0;
   localparam logic [1:0] MODE_OUTPUT = 2'h1;
   localparam logic [1:0] MODE_BIDIR = 2'h2;
   localparam logic [1:0] MODE_OPEN_DRAIN = 2'h3;
   // =====================================================================
   // reset values
   localparam logic [31:0] RST_MODE = 32'h0000_0000;
   localparam logic [31:0] RST_OUT = 32'h0000_0000;
   localparam logic [31:0] RST_FUNC = 32'h0000_0000;
   localparam logic [31:0] RST_DRV = 32'h0000_0000;
   localparam logic [31:0] RST_PWM = 32'h0000_0000;
endpackage

// file: testbench/gpp_board.sv
/*
 gpp_board: board side of the nine pins, with pull-ups and an optional external driver.
 assumes: the external driver is enabled only while the port leaves the pins undriven.
*/
`timescale 1ns/10ps
module gpp_board (
   input wire logic [8:0] pin_out,
   input wire logic [8:0] pin_oe_n,
   input wire logic ext_en,
   input wire logic [8:0] ext_val,
   output logic [8:0] pin_in
);
   // ==========================================
   // wire level
   // a released pin rises on its pull-up, which open-drain use depends on
   always_comb begin
      for (int i = 0; i < 9; i++) begin
         pin_in[i] = !pin_oe_n[i] ? pin_out[i] : (ext_en ? ext_val[i] : 1'b1);
      end
   end
endmodule // gpp_board

// file: testbench/gpp_port_props.sv
/*
 gpp_port_props: pin drive checks for gpp_port, bound to its ports.
 assumes: register writes land at the edge where pready is seen with penable.
*/
`timescale 1ns/10ps
module gpp_port_props #(
   parameter int NUM_PINS = 9,
   parameter int NUM_PWM = 4
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic role_strap,
   input wire logic [NUM_PINS-1:0] pin_out,
   input wire logic [NUM_PINS-1:0] pin_oe_n
);
   // ==========================================
   // register shadow
   logic [31:0] sh_q [8];
   logic [NUM_PINS-1:0] inm, outm, bim, odm, o, d, f;
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         for (int i = 0; i < 8; i++)
            sh_q[i] <= '0;
      end else if (psel && penable && pready && pwrite && !pslverr && paddr[7:5] == 3'h0) begin
         sh_q[paddr[4:2]] <= pwdata;
      end
   end
   always_comb begin
      for (int i = 0; i < NUM_PINS; i++) begin
         inm[i] = sh_q[0][2*i+:2] == gpp_pkg::MODE_INPUT;
         outm[i] = sh_q[0][2*i+:2] == gpp_pkg::MODE_OUTPUT;
         bim[i] = sh_q[0][2*i+:2] == gpp_pkg::MODE_BIDIR;
         odm[i] = sh_q[0][2*i+:2] == gpp_pkg::MODE_OPEN_DRAIN;
         o[i] = sh_q[1][i];
         d[i] = sh_q[4][i];
         f[i] = (i < NUM_PWM) && sh_q[3][i];
      end
   end
   // ==========================================
   // properties
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   reset_idle_a: assert property ($rose(nrst) |-> (&pin_oe_n) [*3])
      else $error("pin driven right after reset");
   secondary_quiet_a: assert property (!role_strap |-> &pin_oe_n)
      else $error("secondary drives a pin");
   input_quiet_a: assert property ((~pin_oe_n & $past(inm)) == '0)
      else $error("input pin driven");
   out_drive_a: assert property (role_strap |-> ($past(outm) & pin_oe_n) == '0)
      else $error("output pin not driven");
   out_value_a: assert property (role_strap |-> ((pin_out ^ $past(o)) & $past(outm & ~f)) == '0)
      else $error("output pin value wrong");
   bidir_drive_a: assert property (role_strap |-> ((~pin_oe_n ^ $past(d)) & $past(bim & ~f)) == '0)
      else $error("bidirectional drive wrong");
   od_low_only_a: assert property ((pin_out & ~pin_oe_n & $past(odm)) == '0)
      else $error("open-drain pin driven high");
   od_release_a: assert property (role_strap |-> ((pin_oe_n ^ $past(o)) & $past(odm & ~f)) == '0)
      else $error("open-drain release wrong");
endmodule // gpp_port_props

bind gpp_port gpp_port_props #(.NUM_PINS(NUM_PINS), .NUM_PWM(NUM_PWM)) u_props (.clk(clk), .nrst(nrst),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
   .pslverr(pslverr), .role_strap(role_strap), .pin_out(pin_out), .pin_oe_n(pin_oe_n));

// file: testbench/test_gpio_pwm_pin_port.sv
/*
 test_gpio_pwm_pin_port: apb scenarios for gpp_port beside a board model.
 assumes: gpp_pkg compiled first; the checker binds itself.
*/
`timescale 1ns/10ps
module test_gpio_pwm_pin_port;
   logic clk, nrst = 1'b0, ce = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic role_strap = 1'b1, ext_en = 1'b0, pready, pslverr;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rdat;
   logic [8:0] pin_in, pin_out, pin_oe_n, ext_val = 9'h000;
   logic [3:0] cnt;
   int mismatches = 0, total_checks = 0;
   gpp_port dut (.clk(clk), .nrst(nrst), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .role_strap(role_strap), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n));
   gpp_board board (.pin_out(pin_out), .pin_oe_n(pin_oe_n), .ext_en(ext_en), .ext_val(ext_val), .pin_in(pin_in));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // ==========================================
   // tasks
   task automatic print_verdict();
      if (mismatches == 0 && total_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task automatic chk(string n, logic [31:0] s, logic [31:0] e);
      total_checks++;
      if (s !== e) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic idle(int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic xfer(logic w, logic [7:0] a, logic [31:0] wd, logic err);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      for (int i = 0; i < 20 && pready !== 1'b1; i++)
         @(posedge clk);
      if (pready !== 1'b1) begin
         mismatches++;
         print_verdict();
      end else begin
         rdat = prdata;
         chk("pslverr", {31'h0, pslverr}, {31'h0, err});
         psel <= 1'b0;
         penable <= 1'b0;
      end
   endtask
   task automatic wr(logic [7:0] a, logic [31:0] wd);
      xfer(1'b1, a, wd, 1'b0);
   endtask
   task automatic rd(logic [7:0] a, logic [31:0] e, string n);
      xfer(1'b0, a, 32'h0, 1'b0);
      chk(n, rdat, e);
   endtask
   // ==========================================
   // scenarios
   initial begin
      idle(10);
      nrst <= 1'b1;
      idle(5);
      chk("oe_n", pin_oe_n, 9'h1FF);
      rd(gpp_pkg::OFF_MODE, gpp_pkg::RST_MODE, "mode");
      rd(gpp_pkg::OFF_STATUS, 32'h0000_0003, "status");
      ext_en <= 1'b1;
      ext_val <= 9'h155;
      idle(3);
      rd(gpp_pkg::OFF_IN, 32'h0000_0155, "in");
      ext_en <= 1'b0;
      wr(gpp_pkg::OFF_OUT, 32'h0000_00AA);
      wr(gpp_pkg::OFF_MODE, 32'h0001_5555);
      idle(2);
      chk("out", pin_out, 9'h0AA);
      chk("oe_n", pin_oe_n, 9'h000);
      wr(gpp_pkg::OFF_OUT, 32'h0000_00F0);
      wr(gpp_pkg::OFF_MODE, 32'h0003_FFFF);
      idle(3);
      chk("oe_n", pin_oe_n, 9'h0F0);
      chk("out", pin_out, 9'h000);
      rd(gpp_pkg::OFF_IN, 32'h0000_00F0, "in");
      wr(gpp_pkg::OFF_DRV, 32'h0000_0003);
      wr(gpp_pkg::OFF_MODE, 32'h0002_AAAA);
      idle(2);
      chk("oe_n", pin_oe_n, 9'h1FC);
      xfer(1'b0, 8'h18, 32'h0, 1'b1);
      chk("unmapped", rdat, 32'h0);
      // bit 4 of the select has no channel, so pin 4 must keep its plain value
      wr(gpp_pkg::OFF_PWM0, 32'h0002_0004);
      wr(gpp_pkg::OFF_OUT, 32'h0000_0010);
      wr(gpp_pkg::OFF_MODE, 32'h0001_5555);
      wr(gpp_pkg::OFF_FUNC, 32'h0000_0011);
      idle(3);
      chk("pin4", {31'h0, pin_out[4]}, 32'h1);
      cnt = 4'h0;
      repeat (8) begin
         @(posedge clk);
         cnt = cnt + {3'h0, pin_out[0]};
      end
      chk("pwm_high", {28'h0, cnt}, 32'h4);
      // with ce low the pwm pin must freeze, so the count is 0 or 8
      ce <= 1'b0;
      cnt = 4'h0;
      repeat (8) begin
         @(posedge clk);
         cnt = cnt + {3'h0, pin_out[0]};
      end
      chk("ce_freeze", {29'h0, cnt[2:0]}, 32'h0);
      ce <= 1'b1;
      nrst <= 1'b0;
      role_strap <= 1'b0;
      idle(10);
      nrst <= 1'b1;
      idle(5);
      wr(gpp_pkg::OFF_MODE, 32'h0001_5555);
      idle(3);
      chk("oe_n", pin_oe_n, 9'h1FF);
      rd(gpp_pkg::OFF_STATUS, 32'h0000_0002, "status");
      print_verdict();
   end
endmodule // test_gpio_pwm_pin_port
